// File: pkg/bsm_consts.svh
`ifndef BSM_CONSTS_SVH
`define BSM_CONSTS_SVH
// Behaviour
// - Arm bit settable only with input rail present; cleared when rail drops in forward mode.
// - Armed and rail below trip: stop charging, force reverse output on.
// - Backup entry sets input status code to 1100.
// - Backup entry pulses interrupt low; change flag set only if unmasked.
// - Trip threshold is the input floor scaled by a two-bit ratio field.
// - Host writes of 1 to reverse output enable ignored while rail high.
// - Backup trigger sets input gate drive disable, opening port-one pair.
// - Input overvoltage opens port-one pair and moves into backup operation.
// - Without port-one pair at reset, arm bit held at zero.
// - Backup ends on low battery or host clearing reverse output enable.
// - Return-to-port-one write clears drive disable, enables gate, disarms.
// - Port-one gate enable reads 1 only when port-one source is valid.
// - Clearing reverse enable with return bit set: charge, clear return, re-arm.
// - Re-arm transition skips detection and keeps input floor value.
// - Otherwise adapter attach runs the normal power-up detection sequence.
// - Disarmed return: return bit, confirm, clear return, clear reverse enable.
// - Discharge limited for limit codes 00, 01, 10; unlimited for 11.
// - Without gates, converter starts 5 ms after reverse enable goes high.
`define BSM_REG_RETURN      8'h16
`define BSM_REG_CTRL        8'h00
`define BSM_REG_STATUS      8'h01
`define BSM_REG_CFG         8'h02
`define BSM_REG_FLOOR       8'h03
`define BSM_BIT_RETURN      0
`define BSM_BIT_ARM         0
`define BSM_BIT_REV         1
`define BSM_BIT_GATE_DIS    2
`define BSM_BIT_BOTH_DIS    3
`define BSM_BIT_P1_EN       4
`define BSM_BIT_P2_EN       5
`define BSM_BIT_MASK        6
`define BSM_STAT_BACKUP     4'hc
`define BSM_STAT_NONE       4'h0
`define BSM_STAT_ADAPTER    4'h1
`define BSM_LIMIT_OFF       2'h3
`define BSM_CLK_HZ          20000000
`define BSM_START_MS        5
`define BSM_START_CYC       ((`BSM_START_MS * `BSM_CLK_HZ + 999) / 1000)
`endif

// File: pkg/bsm_pkg.sv
package bsm_pkg;
  typedef enum logic [1:0] {
    BSM_FORWARD,
    BSM_BACKUP,
    BSM_REVERSE
  } bsm_mode_type;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bsm_wr_type;
  typedef struct packed {
    logic       rail_present;
    logic       below_trip;
    logic       over_voltage;
    logic       batt_low;
    logic       port_one_valid;
    logic       port_two_valid;
  } bsm_sense_type;
endpackage

// File: rtl/bsm_ctrl.sv
`timescale 1ns/1ns
`include "bsm_consts.svh"
module bsm_ctrl #(
  parameter int START_CYC = `BSM_START_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Register port from the serial slave
  input  wire bsm_pkg::bsm_wr_type reg_wr,
  input  wire logic [7:0]        reg_raddr,
  output logic [7:0]             reg_rdata,
  // Analog sense pins, asynchronous
  input  wire bsm_pkg::bsm_sense_type sense_pin,
  input  wire logic              port_one_pair_found,
  // Power stage controls
  output logic                   charge_enable,
  output logic                   reverse_switching,
  output logic                   port_one_gate_on,
  output logic                   port_two_gate_on,
  output logic                   discharge_limit_on,
  output logic                   detect_run,
  output logic [7:0]             trip_threshold,
  output logic                   int_n
);
  import bsm_pkg::*;

  localparam int CW = $clog2(START_CYC + 1);

  bsm_sense_type s1, s2, s3, sense;
  logic          pair_seen, pair_cap;
  bsm_mode_type  mode;
  logic          backup_arm, reverse_output_enable, return_to_port_one;
  logic          input_gate_drive_disable, both_gates_disable;
  logic          p1_req, p2_req, input_change_mask, input_change_flag;
  logic [3:0]    input_status_code;
  logic [1:0]    backup_trip_ratio, discharge_current_limit, input_overvoltage_level;
  logic [7:0]    input_voltage_floor;
  logic [CW-1:0] start_cnt;
  logic          rail_q, entry, ctrl_wr, rev_clear, rearm;
  logic [7:0]    wd;

  function automatic logic hit(input bsm_wr_type w, input logic [7:0] a);
    return w.wr && (w.addr == a);
  endfunction

  // Three stage input sampling
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sense <= '0;
    end else begin
      s1 <= sense_pin;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < $bits(sense); i++) begin
        if (s2[i] == s3[i]) begin
          sense[i] <= s3[i];
        end
      end
    end
  end

  // Strap capture after reset release
  // Strap is static while powered, so no synchroniser
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_seen <= 1'b0;
      pair_cap  <= 1'b0;
    end else if (!pair_seen) begin
      pair_seen <= 1'b1;
      pair_cap  <= port_one_pair_found;
    end
  end

  assign wd      = reg_wr.data;
  assign ctrl_wr = hit(reg_wr, `BSM_REG_CTRL);
  assign entry = pair_seen && backup_arm && mode == BSM_FORWARD &&
                 ((sense.rail_present && sense.below_trip) || sense.over_voltage);
  assign rev_clear = ctrl_wr && reverse_output_enable && !wd[`BSM_BIT_REV];
  assign rearm = rev_clear && return_to_port_one;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rail_q <= 1'b0;
    end else begin
      rail_q <= sense.rail_present;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= BSM_FORWARD;
    end else if (entry) begin
      mode <= BSM_BACKUP;
    end else if (mode != BSM_FORWARD && (rev_clear || sense.batt_low)) begin
      mode <= BSM_FORWARD;
    end else if (mode == BSM_BACKUP && hit(reg_wr, `BSM_REG_RETURN) &&
                 wd[`BSM_BIT_RETURN]) begin
      mode <= BSM_REVERSE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      backup_arm <= 1'b0;
    end else if (pair_seen && !pair_cap) begin
      backup_arm <= 1'b0;
    // Backup holds the rail itself, so only forward mode disarms
    // rail loss disarms
    end else if (!sense.rail_present && mode == BSM_FORWARD) begin
      backup_arm <= 1'b0;
    end else if (rearm) begin
      backup_arm <= 1'b1;
    // Arm stays set through backup so a return write can clear it
    // return disarms
    end else if (hit(reg_wr, `BSM_REG_RETURN) && wd[`BSM_BIT_RETURN]) begin
      backup_arm <= 1'b0;
    end else if (ctrl_wr) begin
      backup_arm <= wd[`BSM_BIT_ARM] && sense.rail_present;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reverse_output_enable <= 1'b0;
    end else if (entry) begin
      reverse_output_enable <= 1'b1;
    // Battery cutoff wins over any host write
    end else if (sense.batt_low) begin
      reverse_output_enable <= 1'b0;
    // host set blocked while rail high
    end else if (ctrl_wr) begin
      reverse_output_enable <= wd[`BSM_BIT_REV] &&
                               (reverse_output_enable || !sense.rail_present);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      return_to_port_one <= 1'b0;
    end else if (rearm) begin
      return_to_port_one <= 1'b0;
    end else if (hit(reg_wr, `BSM_REG_RETURN)) begin
      return_to_port_one <= wd[`BSM_BIT_RETURN];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_gate_drive_disable <= 1'b0;
      both_gates_disable       <= 1'b0;
      p1_req                   <= 1'b0;
      p2_req                   <= 1'b0;
      input_change_mask        <= 1'b0;
    end else if (entry) begin
      input_gate_drive_disable <= 1'b1;
      p1_req                   <= 1'b0;
    end else if (hit(reg_wr, `BSM_REG_RETURN) && wd[`BSM_BIT_RETURN]) begin
      input_gate_drive_disable <= 1'b0;
      p1_req                   <= 1'b1;
    end else if (ctrl_wr) begin
      input_gate_drive_disable <= wd[`BSM_BIT_GATE_DIS];
      both_gates_disable       <= wd[`BSM_BIT_BOTH_DIS];
      p1_req                   <= wd[`BSM_BIT_P1_EN];
      p2_req                   <= wd[`BSM_BIT_P2_EN];
      input_change_mask        <= wd[`BSM_BIT_MASK];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      backup_trip_ratio       <= 2'h0;
      discharge_current_limit <= `BSM_LIMIT_OFF;
      input_overvoltage_level <= 2'h0;
      input_voltage_floor     <= 8'h00;
    end else begin
      if (hit(reg_wr, `BSM_REG_CFG)) begin
        backup_trip_ratio       <= wd[1:0];
        discharge_current_limit <= wd[3:2];
        input_overvoltage_level <= wd[5:4];
      end
      if (hit(reg_wr, `BSM_REG_FLOOR)) begin
        input_voltage_floor <= wd;
      end
    end
  end

  // threshold scaling
  // Registered, so it settles one clock after a write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_threshold <= 8'h00;
    end else begin
      unique case (backup_trip_ratio)
        2'h0: trip_threshold <= input_voltage_floor - (input_voltage_floor >> 3);
        2'h1: trip_threshold <= input_voltage_floor - (input_voltage_floor >> 2);
        2'h2: trip_threshold <= (input_voltage_floor >> 1) + (input_voltage_floor >> 3);
        2'h3: trip_threshold <= input_voltage_floor >> 1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_status_code <= `BSM_STAT_NONE;
      input_change_flag <= 1'b0;
      int_n             <= 1'b1;
    end else begin
      int_n <= !entry;
      if (entry) begin
        input_status_code <= `BSM_STAT_BACKUP;
      end else if (mode == BSM_FORWARD) begin
        input_status_code <= sense.rail_present ? `BSM_STAT_ADAPTER : `BSM_STAT_NONE;
      end
      // Status read clears the flag; a same-cycle set wins
      if (entry && !input_change_mask) begin
        input_change_flag <= 1'b1;
      end else if (reg_raddr == `BSM_REG_STATUS) begin
        input_change_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      detect_run <= 1'b0;
    end else begin
      detect_run <= sense.rail_present && !rail_q && mode == BSM_FORWARD &&
                    !return_to_port_one;
    end
  end

  // start delay
  // Counter saturates so a long reverse run cannot wrap
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_cnt <= '0;
    end else if (!reverse_output_enable) begin
      start_cnt <= '0;
    end else if (start_cnt != CW'(START_CYC)) begin
      start_cnt <= start_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reverse_switching  <= 1'b0;
      charge_enable      <= 1'b0;
      port_one_gate_on   <= 1'b0;
      port_two_gate_on   <= 1'b0;
      discharge_limit_on <= 1'b0;
    end else begin
      reverse_switching  <= reverse_output_enable &&
        ((start_cnt == CW'(START_CYC)) || (!input_gate_drive_disable && (p1_req || p2_req)));
      charge_enable      <= !reverse_output_enable && mode == BSM_FORWARD;
      port_one_gate_on   <= p1_req && sense.port_one_valid && !input_gate_drive_disable &&
                            !both_gates_disable;
      // Port two ignores the port-one drive disable
      port_two_gate_on   <= p2_req && sense.port_two_valid && !both_gates_disable;
      discharge_limit_on <= mode != BSM_FORWARD &&
                            discharge_current_limit != `BSM_LIMIT_OFF;
    end
  end

  always_comb begin
    unique case (reg_raddr)
      `BSM_REG_RETURN: reg_rdata = {7'h00, return_to_port_one};
      `BSM_REG_CTRL: reg_rdata = {1'b0, input_change_mask, port_two_gate_on, port_one_gate_on,
                                  both_gates_disable, input_gate_drive_disable,
                                  reverse_output_enable, backup_arm};
      `BSM_REG_STATUS: reg_rdata = {2'h0, mode, input_status_code};
      `BSM_REG_CFG: reg_rdata = {input_change_flag, 1'b0, input_overvoltage_level,
                                 discharge_current_limit, backup_trip_ratio};
      `BSM_REG_FLOOR: reg_rdata = input_voltage_floor;
      default: reg_rdata = 8'h00;
    endcase
  end
endmodule

// File: bench/bsm_ctrl_sva.sv
`timescale 1ns/1ns
module bsm_ctrl_chk #(
  parameter int START_CYC = 10
) (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  // Register port
  input wire bsm_pkg::bsm_wr_type   reg_wr,
  input wire logic [7:0]            reg_raddr,
  input wire logic [7:0]            reg_rdata,
  // Sense
  input wire bsm_pkg::bsm_sense_type sense_pin,
  input wire logic                  port_one_pair_found,
  // Power stage
  input wire logic                  charge_enable,
  input wire logic                  reverse_switching,
  input wire logic                  port_one_gate_on,
  input wire logic                  port_two_gate_on,
  input wire logic                  discharge_limit_on,
  input wire logic                  detect_run,
  input wire logic [7:0]            trip_threshold,
  input wire logic                  int_n
);
  import bsm_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_int_one_cycle: assert property (!int_n |=> int_n)
    else $error("interrupt low longer than one cycle");
  a_entry_status: assert property ($fell(int_n) && reg_raddr == 8'h01 |->
    reg_rdata[3:0] == 4'hc) else $error("status not backup at entry");
  a_entry_no_charge: assert property (!int_n |-> ##[0:2] !charge_enable)
    else $error("charging kept at backup entry");
  a_entry_gate_off: assert property (!int_n |-> ##[0:2] !port_one_gate_on)
    else $error("port-one gate kept on at backup entry");
  a_start_no_charge: assert property ($rose(reverse_switching) |-> !charge_enable)
    else $error("reverse switching while charging");
  a_detect_pulse: assert property (detect_run |=> !detect_run)
    else $error("detection pulse too long");
  a_limit_off: assert property ((reg_raddr == 8'h02 && reg_rdata[3:2] == 2'h3)[*2] |->
    !discharge_limit_on) else $error("discharge limited with code 11");
  a_gate_valid: assert property ((!sense_pin.port_one_valid)[*6] |-> !port_one_gate_on)
    else $error("port-one gate on with invalid source");
  a_arm_pair: assert property (reg_raddr == 8'h00 && reg_rdata[0] |-> port_one_pair_found)
    else $error("armed without port-one pair");
  cover property ($fell(int_n));
  cover property ($rose(reverse_switching));
  cover property (detect_run);
  cover property ($rose(charge_enable));
endmodule
bind bsm_ctrl bsm_ctrl_chk #(.START_CYC(START_CYC)) i_bsm_ctrl_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
  .sense_pin(sense_pin), .port_one_pair_found(port_one_pair_found),
  .charge_enable(charge_enable), .reverse_switching(reverse_switching),
  .port_one_gate_on(port_one_gate_on), .port_two_gate_on(port_two_gate_on),
  .discharge_limit_on(discharge_limit_on), .detect_run(detect_run),
  .trip_threshold(trip_threshold), .int_n(int_n));

// File: bench/bsm_host_model.sv
`timescale 1ns/1ns
module bsm_host_model #(
  parameter int SETTLE_CYC = 20
) (
  // Clock
  input wire logic           ref_clk,
  // Register port
  output bsm_pkg::bsm_wr_type reg_wr,
  output logic [7:0]         reg_raddr,
  input wire logic [7:0]     reg_rdata
);
  import bsm_pkg::*;
  initial begin
    reg_wr = '0;
    reg_raddr = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    reg_wr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_raddr <= a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge ref_clk);
  endtask
endmodule

// File: bench/test_backup_supply_mode_control.sv
`timescale 1ns/1ns
module test_backup_supply_mode_control;
  import bsm_pkg::*;
  logic          ref_clk, sys_rst, detect_seen, pair_found;
  bsm_wr_type    reg_wr;
  bsm_sense_type sense_pin;
  logic [7:0]    reg_raddr, reg_rdata, trip_threshold, d;
  logic          charge_enable, reverse_switching, port_one_gate_on, port_two_gate_on;
  logic          discharge_limit_on, detect_run, int_n;
  int            mismatches, compares;
  bsm_ctrl #(.START_CYC(10)) i_bsm_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .sense_pin(sense_pin),
    .port_one_pair_found(pair_found), .charge_enable(charge_enable),
    .reverse_switching(reverse_switching), .port_one_gate_on(port_one_gate_on),
    .port_two_gate_on(port_two_gate_on), .discharge_limit_on(discharge_limit_on),
    .detect_run(detect_run), .trip_threshold(trip_threshold), .int_n(int_n));
  bsm_host_model i_bsm_host_model (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_raddr(reg_raddr), .reg_rdata(reg_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (detect_run === 1'b1) detect_seen <= 1'b1;
  end
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Sampler needs 3-4 cycles, so allow six
  task automatic sense(input logic [5:0] s);
    @(posedge ref_clk);
    sense_pin <= s;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic wait_int();
    int i;
    for (i = 0; i < 40 && int_n !== 1'b0; i++) @(negedge ref_clk);
    if (int_n !== 1'b0) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic t_reset();
    i_bsm_host_model.rd(8'h00, d);
    check("ctrl", d, 8'h00);
    i_bsm_host_model.rd(8'h02, d);
    check("limit", d & 8'h0c, 8'h0c);
    check("int_n", {7'h00, int_n}, 8'h01);
  endtask
  task automatic t_ratio();
    logic [7:0] th [4];
    th = '{8'h70, 8'h60, 8'h50, 8'h40};
    i_bsm_host_model.wr(8'h03, 8'h80);
    for (int r = 0; r < 4; r++) begin
      i_bsm_host_model.wr(8'h02, 8'h0c | 8'(r));
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("threshold", trip_threshold, th[r]);
    end
  endtask
  task automatic t_arm();
    i_bsm_host_model.wr(8'h00, 8'h01);
    i_bsm_host_model.rd(8'h00, d);
    check("arm_norail", d & 8'h01, 8'h00);
    detect_seen = 1'b0;
    sense(6'h22);
    check("detect", {7'h00, detect_seen}, 8'h01);
    i_bsm_host_model.wr(8'h00, 8'h01);
    i_bsm_host_model.rd(8'h00, d);
    check("arm", d & 8'h01, 8'h01);
    i_bsm_host_model.wr(8'h00, 8'h03);
    i_bsm_host_model.rd(8'h00, d);
    check("rev_refused", d & 8'h02, 8'h00);
  endtask
  task automatic t_entry();
    @(posedge ref_clk);
    sense_pin <= 6'h32;
    wait_int();
    i_bsm_host_model.rd(8'h02, d);
    check("flag", d & 8'h80, 8'h80);
    i_bsm_host_model.rd(8'h00, d);
    check("ctrl_entry", d & 8'h06, 8'h06);
    i_bsm_host_model.rd(8'h01, d);
    check("status", d & 8'h0f, 8'h0c);
    i_bsm_host_model.rd(8'h02, d);
    check("flag_clr", d & 8'h80, 8'h00);
    check("charge", {7'h00, charge_enable}, 8'h00);
    check("rev_sw_early", {7'h00, reverse_switching}, 8'h00);
    repeat (12) @(posedge ref_clk);
    check("rev_sw", {7'h00, reverse_switching}, 8'h01);
    sense(6'h22);
  endtask
  task automatic t_return();
    detect_seen = 1'b0;
    i_bsm_host_model.wr(8'h16, 8'h01);
    i_bsm_host_model.rd(8'h00, d);
    check("ret_ctrl", d & 8'h17, 8'h12);
    sense(6'h02);
    sense(6'h22);
    i_bsm_host_model.settle();
    i_bsm_host_model.wr(8'h00, 8'h10);
    i_bsm_host_model.rd(8'h00, d);
    check("rearm", d & 8'h03, 8'h01);
    i_bsm_host_model.rd(8'h16, d);
    check("ret_clr", d & 8'h01, 8'h00);
    i_bsm_host_model.rd(8'h03, d);
    check("floor", d, 8'h80);
    check("no_detect", {7'h00, detect_seen}, 8'h00);
    check("charge_on", {7'h00, charge_enable}, 8'h01);
  endtask
  task automatic t_mask();
    i_bsm_host_model.wr(8'h00, 8'h41);
    i_bsm_host_model.rd(8'h01, d);
    @(posedge ref_clk);
    sense_pin <= 6'h32;
    wait_int();
    i_bsm_host_model.rd(8'h02, d);
    check("masked", d & 8'h80, 8'h00);
    sense(6'h26);
    i_bsm_host_model.rd(8'h00, d);
    check("exit", d & 8'h02, 8'h00);
  endtask
  task automatic t_handover();
    sense(6'h22);
    i_bsm_host_model.wr(8'h00, 8'h01);
    @(posedge ref_clk);
    sense_pin <= 6'h32;
    wait_int();
    sense(6'h22);
    i_bsm_host_model.wr(8'h16, 8'h01);
    i_bsm_host_model.rd(8'h00, d);
    check("ret_disarm", d & 8'h13, 8'h12);
    i_bsm_host_model.wr(8'h16, 8'h00);
    i_bsm_host_model.wr(8'h00, 8'h10);
    i_bsm_host_model.rd(8'h00, d);
    check("stay_disarmed", d & 8'h03, 8'h00);
    i_bsm_host_model.wr(8'h02, 8'h00);
    i_bsm_host_model.wr(8'h00, 8'h01);
    @(posedge ref_clk);
    sense_pin <= 6'h2b;
    wait_int();
    sense(6'h23);
    check("limit_on", {7'h00, discharge_limit_on}, 8'h01);
    i_bsm_host_model.wr(8'h00, 8'h06);
    i_bsm_host_model.wr(8'h00, 8'h26);
    i_bsm_host_model.rd(8'h00, d);
    check("p2_read", d & 8'h33, 8'h22);
    check("p2_gate", {7'h00, port_two_gate_on}, 8'h01);
    i_bsm_host_model.wr(8'h00, 8'h24);
    i_bsm_host_model.rd(8'h00, d);
    check("p2_rev_off", d & 8'h23, 8'h20);
    check("limit_off", {7'h00, discharge_limit_on}, 8'h00);
    i_bsm_host_model.wr(8'h00, 8'h25);
    i_bsm_host_model.rd(8'h00, d);
    check("p2_rearm", d & 8'h01, 8'h01);
  endtask
  task automatic t_no_pair();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    pair_found <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    sense(6'h22);
    i_bsm_host_model.wr(8'h00, 8'h01);
    i_bsm_host_model.rd(8'h00, d);
    check("arm_nopair", d & 8'h01, 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    sense_pin = 6'h00;
    detect_seen = 1'b0;
    mismatches = 0;
    pair_found = 1'b1;
    compares = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_ratio();
    t_arm();
    t_entry();
    t_return();
    t_mask();
    t_handover();
    t_no_pair();
    final_report();
  end
endmodule
